/* shared/event_notify_pkg.sv */
// package for the camera event notification and statistics block
// assumes an apb master on a 40 mhz pclk reaches the registers
package event_notify_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_NOTIFY_SEL = 8'h00;
  localparam logic [7:0] ADDR_NOTIFY_EN = 8'h04;
  localparam logic [7:0] ADDR_NOTIFY_MASK = 8'h08;
  localparam logic [7:0] ADDR_STAT_SEL = 8'h0c;
  localparam logic [7:0] ADDR_STAT_VALUE = 8'h10;
  localparam logic [7:0] ADDR_STAT_CLEAR = 8'h14;
  localparam logic [7:0] ADDR_TRIG_CTRL = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;

  // event type codes, also bit positions of the enable mask
  localparam int NUM_EVENTS = 8;
  localparam logic [2:0] EV_REJ_FRAME = 3'h0;
  localparam logic [2:0] EV_REJ_LINE = 3'h1;
  localparam logic [2:0] EV_DROP_IMG = 3'h2;
  localparam logic [2:0] EV_TIMER1 = 3'h3;
  localparam logic [2:0] EV_TIMER2 = 3'h4;
  localparam logic [2:0] EV_COUNT1 = 3'h5;
  localparam logic [2:0] EV_COUNT2 = 3'h6;
  localparam logic [2:0] EV_SPILL = 3'h7;

  // notification setting values
  localparam logic [1:0] NOTIFY_OFF = 2'h0;
  localparam logic [1:0] NOTIFY_ON = 2'h1;
  localparam logic [1:0] LEGACY_NOTIFY_ON_VALUE = 2'h2;

  // statistic counter codes
  localparam int NUM_STATS = 5;
  localparam logic [2:0] ST_REJ_FRAME = 3'h0;
  localparam logic [2:0] ST_DROP_IMG = 3'h1;
  localparam logic [2:0] ST_RETX_PKT = 3'h2;
  localparam logic [2:0] ST_RETX_DISCARD = 3'h3;
  localparam logic [2:0] ST_PAUSE_RX = 3'h4;

  // field positions and reset values
  localparam int TRIG_ALLOW_BIT = 0;
  localparam int STATUS_QCOUNT_LSB = 8;
  localparam logic [7:0] NOTIFY_MASK_RESET = 8'h00;

endpackage : event_notify_pkg

/* hdl/camera_event_notify_stats.sv */
// event notification, message queue and statistic counters
// assumes one pclk domain; event sources are pulses from same-clock logic
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps

module camera_event_notify_stats
  import event_notify_pkg::*;
#(
  parameter int STAT_WIDTH = 32,
  parameter int MSG_DEPTH = 4,
  parameter int RETX_DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_trig,
  input wire logic line_trig,
  input wire logic buffer_full_drop,
  input wire logic image_discard,
  input wire logic first_timer_done,
  input wire logic second_timer_done,
  input wire logic first_count_done,
  input wire logic second_count_done,
  input wire logic retx_req,
  input wire logic retx_pkt_done,
  input wire logic pause_rx,
  output logic frame_start,
  output logic line_start,
  output logic retx_serve_valid,
  output logic msg_valid,
  output logic [2:0] msg_type,
  input wire logic msg_ready
);

  localparam int QW = $clog2(MSG_DEPTH + 1);
  localparam int RW = $clog2(RETX_DEPTH + 1);
  localparam logic [STAT_WIDTH-1:0] STAT_MAX = '1;

  // behaviour notes
  // - apb: one wait state; read data decoded in the first access cycle
  // - apb: writes land at the edge that shows pready high, not before
  // - event sources are single cycle pulses from logic on pclk
  // - each pulse is one occurrence; a held level counts every cycle
  // - spill event bypasses the enables, the host cannot mute it
  // - spill clears every enable; the host re-enables what it still needs
  // - a spill waits in spill_pend until a queue slot frees
  // - only one spill is held; later overflows merge into it
  // - a waiting spill enters before the events of the same cycle
  // - events of one cycle enter the queue in code order
  // - counters stop at all ones until cleared through the selector
  // - a clear and an increment in one cycle leave the counter zero
  // - selector codes past the last counter read zero, clear nothing
  // - retransmit queue keeps only its fill level, packets live elsewhere
  // - a request and a service in one full cycle both succeed
  // - trig_allow comes up low, so triggers are rejected after reset
  // - msg_type is only meaningful while msg_valid is high
  // - msg_valid is kept in a flip-flop, not decoded from the count
  // - writes to read-only offsets are answered but change nothing
  // - unmapped offsets answer with pslverr and zero data
  // - pslverr and prdata stand for the single cycle of pready

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] notify_type_select;
    logic [NUM_EVENTS-1:0] notify_enable;
    logic [2:0] stat_counter_select;
    logic trig_allow;
    logic [NUM_STATS-1:0][STAT_WIDTH-1:0] stat;
    logic [MSG_DEPTH-1:0][2:0] msg_q;
    logic [QW-1:0] msg_cnt;
    logic msg_valid;
    logic spill_pend;
    logic [RW-1:0] retx_cnt;
    logic frame_start;
    logic line_start;
    logic retx_serve_valid;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  ////////////////////////////////////////////////////////////////
  // saturating increment of one statistic
  function automatic logic [STAT_WIDTH-1:0] sat_inc(input logic [STAT_WIDTH-1:0] v);
    sat_inc = (v == STAT_MAX) ? v : v + 1'b1;
  endfunction : sat_inc

  // apb access decode
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////
  // event, queue, counter and register logic
  logic [NUM_EVENTS-1:0] ev_raw;
  logic [NUM_STATS-1:0] st_inc;
  logic acc;
  logic first_acc;
  logic wr;
  logic pop;
  logic retx_full;
  logic retx_deq;
  logic retx_take;
  logic [1:0] wval;

  // one hit line per register offset
  logic hit_sel;
  logic hit_en;
  logic hit_mask;
  logic hit_ssel;
  logic hit_sval;
  logic hit_sclr;
  logic hit_trig;
  logic hit_status;
  logic hit_none;

  ////////////////////////////////////////////////////////////////
  // legacy value behaves exactly like on; anything else is off
  function automatic logic notify_on(input logic [1:0] v);
    notify_on = (v == NOTIFY_ON) || (v == LEGACY_NOTIFY_ON_VALUE);
  endfunction : notify_on

  // selector codes past the last counter select nothing
  function automatic logic stat_sel_ok(input logic [2:0] s);
    stat_sel_ok = (s < 3'(NUM_STATS));
  endfunction : stat_sel_ok

  // message queue has no free slot
  function automatic logic msg_full(input logic [QW-1:0] c);
    msg_full = (c == QW'(MSG_DEPTH));
  endfunction : msg_full

  // next free slot of the message queue
  function automatic logic [$clog2(MSG_DEPTH)-1:0] slot_of(input logic [QW-1:0] c);
    slot_of = c[$clog2(MSG_DEPTH)-1:0];
  endfunction : slot_of

  // enable of one event type out of the mask
  function automatic logic enable_bit(input logic [NUM_EVENTS-1:0] m, input logic [2:0] s);
    enable_bit = m[s];
  endfunction : enable_bit

  // status word: retransmit fill above message fill
  function automatic logic [31:0] status_word(input logic [RW-1:0] r, input logic [QW-1:0] m);
    status_word = {16'h0000, 8'(r), 8'(m)};
  endfunction : status_word

  ////////////////////////////////////////////////////////////////
  // next state of every register
  always_comb begin
    // defaults: hold state, single cycle outputs low
    nxt_st = st_ff;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata = '0;
    nxt_st.frame_start = 1'b0;
    nxt_st.line_start = 1'b0;
    ev_raw = '0;
    st_inc = '0;

    // apb phases: decode in the first access cycle, write when answered
    acc = psel && penable;
    first_acc = acc && !st_ff.pready;
    wr = acc && pwrite && st_ff.pready;
    wval = pwdata[1:0];

    // address decode, one hit at most
    hit_sel = 1'b0;
    hit_en = 1'b0;
    hit_mask = 1'b0;
    hit_ssel = 1'b0;
    hit_sval = 1'b0;
    hit_sclr = 1'b0;
    hit_trig = 1'b0;
    hit_status = 1'b0;
    hit_none = 1'b0;
    if (addr_hit(paddr, ADDR_NOTIFY_SEL)) begin
      hit_sel = 1'b1;
    end else if (addr_hit(paddr, ADDR_NOTIFY_EN)) begin
      hit_en = 1'b1;
    end else if (addr_hit(paddr, ADDR_NOTIFY_MASK)) begin
      hit_mask = 1'b1;
    end else if (addr_hit(paddr, ADDR_STAT_SEL)) begin
      hit_ssel = 1'b1;
    end else if (addr_hit(paddr, ADDR_STAT_VALUE)) begin
      hit_sval = 1'b1;
    end else if (addr_hit(paddr, ADDR_STAT_CLEAR)) begin
      hit_sclr = 1'b1;
    end else if (addr_hit(paddr, ADDR_TRIG_CTRL)) begin
      hit_trig = 1'b1;
    end else if (addr_hit(paddr, ADDR_STATUS)) begin
      hit_status = 1'b1;
    end else begin
      hit_none = 1'b1;
    end

    // rejected frame trigger: no acquisition, event and statistic
    if (frame_trig && !st_ff.trig_allow) begin
      ev_raw[EV_REJ_FRAME] = 1'b1;
      st_inc[ST_REJ_FRAME] = 1'b1;
    end

    // rejected line trigger: no line, event only
    if (line_trig && !st_ff.trig_allow) begin
      ev_raw[EV_REJ_LINE] = 1'b1;
    end

    // allowed triggers start their acquisition one cycle later
    if (frame_trig && st_ff.trig_allow) begin
      nxt_st.frame_start = 1'b1;
    end
    if (line_trig && st_ff.trig_allow) begin
      nxt_st.line_start = 1'b1;
    end

    // memory, timer and counter event sources
    ev_raw[EV_DROP_IMG] = buffer_full_drop;
    ev_raw[EV_TIMER1] = first_timer_done;
    ev_raw[EV_TIMER2] = second_timer_done;
    ev_raw[EV_COUNT1] = first_count_done;
    ev_raw[EV_COUNT2] = second_count_done;

    // retransmit request queue: only its fill level lives here
    retx_full = (st_ff.retx_cnt == RW'(RETX_DEPTH));
    retx_deq = retx_pkt_done && (st_ff.retx_cnt != '0);
    retx_take = retx_req && (!retx_full || retx_deq);
    if (retx_deq && !retx_take) begin
      nxt_st.retx_cnt = st_ff.retx_cnt - 1'b1;
    end else if (retx_take && !retx_deq) begin
      nxt_st.retx_cnt = st_ff.retx_cnt + 1'b1;
    end
    nxt_st.retx_serve_valid = (nxt_st.retx_cnt != '0);

    // remaining statistic sources
    st_inc[ST_DROP_IMG] = image_discard;
    st_inc[ST_RETX_PKT] = retx_deq;
    st_inc[ST_RETX_DISCARD] = retx_req && !retx_take;
    st_inc[ST_PAUSE_RX] = pause_rx;

    // saturating increments, one per counter
    for (int i = 0; i < NUM_STATS; i++) begin
      if (st_inc[i]) begin
        nxt_st.stat[i] = sat_inc(st_ff.stat[i]);
      end
    end

    // head leaves the queue when the host takes it
    pop = (st_ff.msg_cnt != '0) && msg_ready;
    if (pop) begin
      for (int k = 0; k < MSG_DEPTH - 1; k++) begin
        nxt_st.msg_q[k] = st_ff.msg_q[k + 1];
      end
      nxt_st.msg_cnt = st_ff.msg_cnt - 1'b1;
    end

    // waiting spill goes in first, so a spill raised now is not lost
    if (st_ff.spill_pend && !msg_full(nxt_st.msg_cnt)) begin
      nxt_st.msg_q[slot_of(nxt_st.msg_cnt)] = EV_SPILL;
      nxt_st.msg_cnt = nxt_st.msg_cnt + 1'b1;
      nxt_st.spill_pend = 1'b0;
    end

    // enabled events in code order; no room clears every enable
    for (int e = 0; e < NUM_EVENTS - 1; e++) begin
      if (ev_raw[e] && nxt_st.notify_enable[e]) begin
        if (msg_full(nxt_st.msg_cnt)) begin
          nxt_st.notify_enable = '0;
          nxt_st.spill_pend = 1'b1;
        end else begin
          nxt_st.msg_q[slot_of(nxt_st.msg_cnt)] = 3'(e);
          nxt_st.msg_cnt = nxt_st.msg_cnt + 1'b1;
        end
      end
    end
    nxt_st.msg_valid = (nxt_st.msg_cnt != '0);

    // apb read side: data and error registered for the answer cycle
    nxt_st.pready = first_acc;
    if (first_acc) begin
      if (hit_sel) begin
        nxt_st.prdata = 32'(st_ff.notify_type_select);
      end else if (hit_en) begin
        nxt_st.prdata = 32'(enable_bit(st_ff.notify_enable, st_ff.notify_type_select));
      end else if (hit_mask) begin
        nxt_st.prdata = 32'(st_ff.notify_enable);
      end else if (hit_ssel) begin
        nxt_st.prdata = 32'(st_ff.stat_counter_select);
      end else if (hit_sval) begin
        if (stat_sel_ok(st_ff.stat_counter_select)) begin
          nxt_st.prdata = 32'(st_ff.stat[st_ff.stat_counter_select]);
        end
      end else if (hit_sclr) begin
        nxt_st.prdata = '0;
      end else if (hit_trig) begin
        nxt_st.prdata = 32'(st_ff.trig_allow);
      end else if (hit_status) begin
        nxt_st.prdata = status_word(st_ff.retx_cnt, st_ff.msg_cnt);
      end else if (hit_none) begin
        nxt_st.pslverr = 1'b1;
      end
    end

    // apb write side: lands at the edge that shows pready high
    if (wr) begin
      if (hit_sel) begin
        nxt_st.notify_type_select = pwdata[2:0];
      end else if (hit_en) begin
        nxt_st.notify_enable[st_ff.notify_type_select] = notify_on(wval);
      end else if (hit_ssel) begin
        nxt_st.stat_counter_select = pwdata[2:0];
      end else if (hit_sclr) begin
        if (pwdata[0] && stat_sel_ok(st_ff.stat_counter_select)) begin
          nxt_st.stat[st_ff.stat_counter_select] = '0;
        end
      end else if (hit_trig) begin
        nxt_st.trig_allow = pwdata[TRIG_ALLOW_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register, cleared by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state flip-flops
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign frame_start = st_ff.frame_start;
  assign line_start = st_ff.line_start;
  assign retx_serve_valid = st_ff.retx_serve_valid;
  assign msg_valid = st_ff.msg_valid;
  assign msg_type = st_ff.msg_q[0];

endmodule : camera_event_notify_stats

/* testbench/camera_event_notify_stats_properties.sv */
// port assertions for the event notify block
// assumes a bind onto camera_event_notify_stats, one pclk domain
`timescale 1ns/1ps
module camera_event_notify_stats_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_trig,
  input wire logic line_trig,
  input wire logic frame_start,
  input wire logic line_start,
  input wire logic retx_req,
  input wire logic retx_pkt_done,
  input wire logic retx_serve_valid,
  input wire logic msg_valid,
  input wire logic [2:0] msg_type,
  input wire logic msg_ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase waiting, then a one cycle answer
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_ans; pready ##1 !pready; endsequence
  //////////////////////////////////////
  AST_APB_ANSWER: assert property (s_wait |=> s_ans)
    else $error("apb answer late");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable && $past(psel))
    else $error("ready outside access");
  AST_SLVERR_READY: assert property (pslverr |-> pready)
    else $error("slverr without ready");
  AST_FRAME_START: assert property (frame_start |-> $past(frame_trig))
    else $error("frame start without trigger");
  AST_LINE_START: assert property (line_start |-> $past(line_trig))
    else $error("line start without trigger");
  AST_RETX_HELD: assert property (retx_req && !retx_pkt_done |=> retx_serve_valid)
    else $error("request not queued");
  AST_RETX_DRAIN: assert property ($fell(retx_serve_valid) |-> $past(retx_pkt_done))
    else $error("queue emptied without service");
  AST_MSG_HOLD: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_type))
    else $error("message lost while stalled");
endmodule : camera_event_notify_stats_checker
bind camera_event_notify_stats camera_event_notify_stats_checker u_checker (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .frame_trig, .line_trig, .frame_start, .line_start, .retx_req,
  .retx_pkt_done, .retx_serve_valid, .msg_valid, .msg_type, .msg_ready);

/* testbench/host_msg_sink.sv */
// host side sink for event messages, counts what it takes
// assumes msg_valid and msg_type from the block on pclk
`timescale 1ns/1ps
module host_msg_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic msg_valid,
  input wire logic [2:0] msg_type,
  input wire logic stall,
  input wire logic fast,
  output logic msg_ready,
  output logic [31:0] taken,
  output logic [2:0] last
);
  // full rate or every other cycle, low while stalled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_ready <= 1'b0;
      taken <= '0;
      last <= '0;
    end else begin
      msg_ready <= !stall && (fast || !msg_ready);
      if (msg_valid && msg_ready) begin
        taken <= taken + 32'h1;
        last <= msg_type;
      end
    end
  end
endmodule : host_msg_sink

/* testbench/tb.sv */
// testbench: apb register tasks and pulsed event sources
// assumes the package, the sink model and the checker compile first
`timescale 1ns/1ps
module tb;
  import event_notify_pkg::*;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, stall = '0, fast = '1, sawfs = '0;
  logic sawls = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat, taken;
  logic pready, pslverr, serr, msg_valid, msg_ready, fs, ls, rv;
  logic [2:0] msg_type, last;
  logic [10:0] src = '0;
  logic [31:0] exp_st [5];
  int miscompares = 0, checks = 0, cyc = 0, n = 0;
  camera_event_notify_stats #(.STAT_WIDTH(3)) u_camera_event_notify_stats (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .frame_trig(src[0]), .line_trig(src[1]), .buffer_full_drop(src[2]), .first_timer_done(src[3]),
    .second_timer_done(src[4]), .first_count_done(src[5]), .second_count_done(src[6]),
    .image_discard(src[7]), .retx_req(src[8]), .retx_pkt_done(src[9]), .pause_rx(src[10]),
    .frame_start(fs), .line_start(ls), .retx_serve_valid(rv), .msg_valid, .msg_type, .msg_ready);
  host_msg_sink u_host_msg_sink (.pclk, .presetn, .msg_valid, .msg_type, .stall, .fast, .msg_ready, .taken, .last);
  // clock, timeout and frame and line start monitor
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (fs === 1'b1) sawfs <= 1'b1;
    if (ls === 1'b1) sawls <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  //////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rdat, exp);
  endtask : rd
  task automatic pulse(input int i, input int k);
    repeat (k) begin
      src[i] <= 1'b1;
      @(posedge pclk);
      src[i] <= 1'b0;
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask : pulse
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  //////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd("mask", ADDR_NOTIFY_MASK, 32'h0);
    rd("stat", ADDR_STAT_VALUE, 32'h0);
    rd("unmapped", 8'h20, 32'h0);
    check("slverr", serr, 32'h1);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ADDR_NOTIFY_SEL, i);
      apb(1'b1, ADDR_NOTIFY_EN, i[0] ? LEGACY_NOTIFY_ON_VALUE : NOTIFY_ON);
      rd("mask", ADDR_NOTIFY_MASK, (2 << i) - 1);
    end
    rd("sel en", ADDR_NOTIFY_EN, 32'h1);
    for (int i = 0; i < 7; i++) begin
      pulse(i, 1);
      n++;
      check("msgs", taken, n);
      check("type", last, i);
    end
    check("no start", sawfs, 32'h0);
    check("no line start", sawls, 32'h0);
    apb(1'b1, ADDR_NOTIFY_SEL, EV_DROP_IMG);
    apb(1'b1, ADDR_NOTIFY_EN, NOTIFY_OFF);
    pulse(2, 1);
    check("msgs", taken, n);
    // stalled host, five pushes overflow the four slot queue
    stall <= 1'b1;
    pulse(3, 5);
    rd("mask", ADDR_NOTIFY_MASK, 32'h0);
    stall <= 1'b0;
    fast <= 1'b0;
    repeat (20) @(posedge pclk);
    n += 5;
    check("msgs", taken, n);
    check("type", last, EV_SPILL);
    apb(1'b1, ADDR_NOTIFY_SEL, EV_TIMER1);
    apb(1'b1, ADDR_NOTIFY_EN, NOTIFY_ON);
    pulse(3, 1);
    check("msgs", taken, n + 1);
    // statistics: three more rejected triggers, then one allowed
    pulse(0, 3);
    apb(1'b1, ADDR_TRIG_CTRL, 32'h1);
    pulse(0, 1);
    check("start", sawfs, 32'h1);
    pulse(1, 1);
    check("line start", sawls, 32'h1);
    pulse(7, 2);
    pulse(8, 6);
    check("queued", rv, 32'h1);
    pulse(9, 4);
    check("drained", rv, 32'h0);
    pulse(10, 9);
    exp_st = '{32'h4, 32'h2, 32'h4, 32'h2, 32'h7};
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 5; i++) begin
        apb(1'b1, ADDR_STAT_SEL, i);
        rd("stat", ADDR_STAT_VALUE, exp_st[i]);
      end
      apb(1'b1, ADDR_STAT_SEL, ST_DROP_IMG);
      apb(1'b1, ADDR_STAT_CLEAR, 32'h1);
      exp_st[1] = 32'h0;
    end
    summarize();
  end
endmodule : tb
